// >>> core/obp_fifo.sv
// file: small valid/ready fifo for programming data
`timescale 1ns/1ps
module obp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic push, pop;
    always_comb begin
        in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
        out_valid = wr_ptr != rd_ptr;
        out_data = mem[rd_ptr[AW-1:0]];
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        next_wr_ptr = wr_ptr + (AW+1)'(push);
        next_rd_ptr = rd_ptr + (AW+1)'(pop);
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end
    // storage has no reset, only pointers matter
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
endmodule : obp_fifo

// >>> core/obp_pkg.sv
// package: constants, types and timing for the byte program sequencer
package obp_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 8;
    localparam int CLK_MHZ = 250;
    // pulse width: nominal 100 us inside the 95..105 us window
    localparam int PULSE_US_MIN = 95;
    localparam int PULSE_US_MAX = 105;
    localparam int PULSE_US_NOM = 100;
    localparam int PULSE_CYC = PULSE_US_NOM * CLK_MHZ;
    localparam int PULSE_CYC_MIN = PULSE_US_MIN * CLK_MHZ;
    localparam int PULSE_CYC_MAX = PULSE_US_MAX * CLK_MHZ;
    // setup / hold 2 us
    localparam int SETUP_US = 2;
    localparam int SETUP_CYC = SETUP_US * CLK_MHZ;
    // read access settle, 150 ns data valid from output enable
    localparam int READ_NS = 150;
    localparam int READ_CYC = (READ_NS * CLK_MHZ + 999) / 1000;
    // supply settle before use, our choice
    localparam int SUPPLY_US = 10;
    localparam int SUPPLY_CYC = SUPPLY_US * CLK_MHZ;
    localparam int RETRY_MAX = 10;
    localparam int FIFO_DEPTH = 8;
    // supply levels as codes for the external regulator
    localparam logic [1:0] SUP_OFF = 2'h0;
    localparam logic [1:0] SUP_NOM = 2'h1;
    localparam logic [1:0] SUP_PROG = 2'h2;
    typedef struct packed {
        logic [1:0] vcc;
        logic [1:0] vpp;
        logic id_hv;
    } obp_supply_s;
    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic program_strobe_n;
    } obp_strobe_s;
    typedef enum logic [1:0] {
        OBP_RES_NONE = 2'h0,
        OBP_RES_PASS = 2'h1,
        OBP_RES_FAIL = 2'h2
    } obp_result_e;
endpackage : obp_pkg

// >>> core/obp_sequencer.sv
// file: programmer that drives an otp byte memory through its pins
`timescale 1ns/1ps
module obp_sequencer
    import obp_pkg::*;
#(
    parameter int ADDR_W_P = ADDR_W,
    parameter int PULSE_CYC_P = PULSE_CYC,
    parameter int SETUP_CYC_P = SETUP_CYC,
    parameter int SUPPLY_CYC_P = SUPPLY_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // command
    input wire logic start,
    input wire logic id_start,
    input wire logic [obp_pkg::ADDR_W-1:0] last_addr,
    // programming data stream, one byte per address in order
    input wire logic data_valid,
    output logic data_ready,
    input wire logic [obp_pkg::DATA_W-1:0] data_byte,
    // status
    output logic busy,
    output logic done,
    output obp_pkg::obp_result_e result,
    output logic [obp_pkg::ADDR_W-1:0] fail_addr,
    output logic [obp_pkg::DATA_W-1:0] maker_code,
    output logic [obp_pkg::DATA_W-1:0] device_code,
    // memory pins
    output logic [obp_pkg::ADDR_W-1:0] mem_addr,
    output obp_pkg::obp_strobe_s mem_strobe,
    output obp_pkg::obp_supply_s mem_supply,
    output logic [obp_pkg::DATA_W-1:0] mem_dq_out,
    output logic mem_dq_oe,
    input wire logic [obp_pkg::DATA_W-1:0] mem_dq_in
);
    initial begin
        if (ADDR_W_P != ADDR_W) $error("address width must match package");
        if (PULSE_CYC_P < 1 || SETUP_CYC_P < 1 || SUPPLY_CYC_P < 1) $error("counts must be positive");
    end

    typedef enum logic [3:0] {
        S_IDLE = 4'h0, S_VCC_UP = 4'h1, S_VPP_UP = 4'h2, S_P1_SET = 4'h3,
        S_PULSE = 4'h4, S_HOLD = 4'h5, S_VFY_RD = 4'h6, S_VFY_CMP = 4'h7,
        S_VPP_DN = 4'h8, S_VCC_DN = 4'h9, S_FIN_RD = 4'ha, S_ID_RD = 4'hb
    } obp_state_e;

    // pass: 0 first pass, 1 verify loop, 2 final read, 3 id or failed run
    typedef struct packed {
        obp_state_e st;
        logic [1:0] pass;
        logic [17:0] addr;
        logic [24:0] cnt;
        logic [3:0] tries;
        logic id_sel;
        obp_strobe_s strobe;
        obp_supply_s supply;
        logic dq_oe;
        logic busy;
        logic done;
        obp_result_e result;
        logic [17:0] fail_addr;
        logic [7:0] maker;
        logic [7:0] device;
    } obp_ctl_s;

    obp_ctl_s c, n;
    logic [7:0] rd_s1, rd_s2;
    // image of the bytes, the stream is consumed once in the first pass
    logic [7:0] image [1 << 18];
    logic img_wr;
    logic [7:0] img_byte;
    logic f_valid, f_ready;
    logic [7:0] f_data;
    logic cnt_done;

    obp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_valid(data_valid),
        .in_ready(data_ready),
        .in_data(data_byte),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    // data pins cross from the memory, two flops before use
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_s1 <= '0;
            rd_s2 <= '0;
        end else begin
            rd_s1 <= mem_dq_in;
            rd_s2 <= rd_s1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (img_wr) begin
            image[c.addr] <= f_data;
        end
    end
    assign img_byte = image[c.addr];

    always_comb begin
        n = c;
        img_wr = 1'b0;
        f_ready = 1'b0;
        n.done = 1'b0;
        cnt_done = c.cnt == '0;
        if (!cnt_done) begin
            n.cnt = c.cnt - 25'h1;
        end
        unique case (c.st)
            S_IDLE: begin
                n.strobe = '{ce_n: 1'b1, oe_n: 1'b1, program_strobe_n: 1'b1};
                n.dq_oe = 1'b0;
                n.addr = '0;
                n.tries = '0;
                if (start) begin
                    n.busy = 1'b1;
                    n.result = OBP_RES_NONE;
                    n.pass = 2'h0;
                    n.supply.vcc = SUP_PROG;
                    n.cnt = 25'(SUPPLY_CYC_P);
                    n.st = S_VCC_UP;
                end else if (id_start) begin
                    n.busy = 1'b1;
                    n.pass = 2'h3;
                    n.id_sel = 1'b0;
                    n.supply = '{vcc: SUP_NOM, vpp: SUP_NOM, id_hv: 1'b1};
                    n.strobe = '{ce_n: 1'b0, oe_n: 1'b0, program_strobe_n: 1'b1};
                    n.cnt = 25'(SETUP_CYC_P);
                    n.st = S_ID_RD;
                end
            end
            S_VCC_UP: if (cnt_done) begin
                n.supply.vpp = SUP_PROG;
                n.cnt = 25'(SUPPLY_CYC_P);
                n.st = S_VPP_UP;
            end
            S_VPP_UP: if (cnt_done) begin
                n.strobe.ce_n = 1'b0;
                n.st = S_P1_SET;
                n.cnt = 25'(SETUP_CYC_P);
            end
            S_P1_SET: begin
                // first pass waits for the byte; later passes reuse the image
                if (c.pass == 2'h0 && !c.dq_oe) begin
                    if (f_valid) begin
                        f_ready = 1'b1;
                        img_wr = 1'b1;
                        n.dq_oe = 1'b1;
                        n.cnt = 25'(SETUP_CYC_P);
                    end
                end else if (cnt_done) begin
                    n.strobe.program_strobe_n = 1'b0;
                    n.cnt = 25'(PULSE_CYC_P);
                    n.st = S_PULSE;
                end
            end
            S_PULSE: if (cnt_done) begin
                n.strobe.program_strobe_n = 1'b1;
                n.cnt = 25'(SETUP_CYC_P);
                n.st = S_HOLD;
            end
            S_HOLD: if (cnt_done) begin
                n.dq_oe = 1'b0;
                if (c.pass == 2'h0) begin
                    // no verify in the first pass
                    if (c.addr == last_addr) begin
                        n.addr = '0;
                        n.pass = 2'h1;
                    end else begin
                        n.addr = c.addr + 18'h1;
                    end
                    n.cnt = 25'(SETUP_CYC_P);
                    n.st = S_P1_SET;
                    if (c.addr == last_addr) begin
                        n.strobe.oe_n = 1'b0;
                        n.st = S_VFY_RD;
                    end
                end else begin
                    n.strobe.oe_n = 1'b0;
                    n.st = S_VFY_RD;
                end
            end
            S_VFY_RD: if (cnt_done) begin
                // extra cycles cover the pin synchroniser
                n.cnt = 25'h3;
                n.st = S_VFY_CMP;
            end
            S_VFY_CMP: if (cnt_done) begin
                n.strobe.oe_n = 1'b1;
                n.cnt = 25'(SETUP_CYC_P);
                if (rd_s2 == img_byte) begin
                    n.tries = '0;
                    if (c.addr == last_addr) begin
                        n.supply.vpp = SUP_NOM;
                        n.cnt = 25'(SUPPLY_CYC_P);
                        n.st = S_VPP_DN;
                    end else begin
                        n.addr = c.addr + 18'h1;
                        n.strobe.oe_n = 1'b0;
                        n.st = S_VFY_RD;
                    end
                end else if (c.tries == 4'(RETRY_MAX)) begin
                    n.fail_addr = c.addr;
                    n.result = OBP_RES_FAIL;
                    n.supply.vpp = SUP_NOM;
                    n.cnt = 25'(SUPPLY_CYC_P);
                    n.pass = 2'h3;
                    n.st = S_VPP_DN;
                end else begin
                    n.tries = c.tries + 4'h1;
                    n.dq_oe = 1'b1;
                    n.st = S_P1_SET;
                end
            end
            S_VPP_DN: if (cnt_done) begin
                n.supply.vcc = SUP_NOM;
                n.cnt = 25'(SUPPLY_CYC_P);
                n.st = S_VCC_DN;
            end
            S_VCC_DN: if (cnt_done) begin
                if (c.pass == 2'h3) begin
                    n.strobe = '{ce_n: 1'b1, oe_n: 1'b1, program_strobe_n: 1'b1};
                    n.busy = 1'b0;
                    n.done = 1'b1;
                    n.st = S_IDLE;
                end else begin
                    n.pass = 2'h2;
                    n.addr = '0;
                    n.strobe.oe_n = 1'b0;
                    n.cnt = 25'(SETUP_CYC_P);
                    n.st = S_FIN_RD;
                end
            end
            S_FIN_RD: if (cnt_done) begin
                if (rd_s2 != img_byte) begin
                    n.fail_addr = c.addr;
                    n.result = OBP_RES_FAIL;
                end else if (c.addr == last_addr) begin
                    n.result = OBP_RES_PASS;
                end
                if (rd_s2 != img_byte || c.addr == last_addr) begin
                    n.strobe = '{ce_n: 1'b1, oe_n: 1'b1, program_strobe_n: 1'b1};
                    n.busy = 1'b0;
                    n.done = 1'b1;
                    n.st = S_IDLE;
                end else begin
                    n.addr = c.addr + 18'h1;
                    n.cnt = 25'(SETUP_CYC_P);
                end
            end
            S_ID_RD: if (cnt_done) begin
                // lowest address bit picks the code
                if (!c.id_sel) begin
                    n.maker = rd_s2;
                    n.id_sel = 1'b1;
                    n.addr = 18'h1;
                    n.cnt = 25'(SETUP_CYC_P);
                end else begin
                    n.device = rd_s2;
                    n.supply = '{vcc: SUP_OFF, vpp: SUP_OFF, id_hv: 1'b0};
                    n.strobe = '{ce_n: 1'b1, oe_n: 1'b1, program_strobe_n: 1'b1};
                    n.addr = '0;
                    n.busy = 1'b0;
                    n.done = 1'b1;
                    n.st = S_IDLE;
                end
            end
            default: n.st = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            c <= '{st: S_IDLE, pass: 2'h0, addr: '0, cnt: '0, tries: '0, id_sel: 1'b0,
                   strobe: '{ce_n: 1'b1, oe_n: 1'b1, program_strobe_n: 1'b1},
                   supply: '{vcc: SUP_OFF, vpp: SUP_OFF, id_hv: 1'b0},
                   dq_oe: 1'b0, busy: 1'b0, done: 1'b0, result: OBP_RES_NONE,
                   fail_addr: '0, maker: '0, device: '0};
        end else begin
            c <= n;
        end
    end

    // outputs straight from the control register, except mem_dq_out from the image and data_ready from the fifo
    assign busy = c.busy;
    assign done = c.done;
    assign result = c.result;
    assign fail_addr = c.fail_addr;
    assign maker_code = c.maker;
    assign device_code = c.device;
    assign mem_addr = c.addr;
    assign mem_strobe = c.strobe;
    assign mem_supply = c.supply;
    assign mem_dq_oe = c.dq_oe;
    assign mem_dq_out = img_byte;
endmodule : obp_sequencer

// >>> dv/obp_otp_model.sv
// behavioural otp byte memory on the sequencer pins
`timescale 1ns/1ps
module obp_otp_model
    import obp_pkg::*;
#(
    // arbitrary identity values
    parameter logic [7:0] MAKER = 8'h5a,
    parameter logic [7:0] DEVICE = 8'ha7
) (
    // memory pins
    input wire logic [obp_pkg::ADDR_W-1:0] mem_addr,
    input wire obp_pkg::obp_strobe_s mem_strobe,
    input wire obp_pkg::obp_supply_s mem_supply,
    input wire logic [obp_pkg::DATA_W-1:0] mem_dq_out,
    output logic [obp_pkg::DATA_W-1:0] mem_dq_in,
    // test controls
    input wire logic wipe,
    input wire logic [3:0] hard_addr,
    input wire logic [7:0] hard_n,
    output logic [7:0] hard_pulses
);
    logic [7:0] arr [16];
    logic [7:0] last = 8'h00;
    logic [7:0] val;
    logic drv;
    assign drv = !mem_strobe.ce_n && !mem_strobe.oe_n && mem_supply.vcc != SUP_OFF;
    assign val = mem_supply.id_hv ? (mem_addr[0] ? DEVICE : MAKER) : arr[mem_addr[3:0]];
    always @(drv or val) begin
        if (drv) begin
            last = val;
        end
    end
    // a released bus must not look like the last byte
    assign mem_dq_in = drv ? val : ~last;
    always @(posedge wipe) begin
        foreach (arr[i]) arr[i] = 8'hff;
        hard_pulses = 8'h0;
    end
    // weak cell: zeros only stick after hard_n pulses
    always @(posedge mem_strobe.program_strobe_n) begin
        if (!mem_strobe.ce_n && mem_supply.vcc == SUP_PROG && mem_supply.vpp == SUP_PROG) begin
            if (mem_addr[3:0] == hard_addr) begin
                hard_pulses = hard_pulses + 8'h1;
            end
            if (mem_addr[3:0] != hard_addr || hard_pulses >= hard_n) begin
                arr[mem_addr[3:0]] = arr[mem_addr[3:0]] & mem_dq_out;
            end
        end
    end
endmodule : obp_otp_model

// >>> dv/obp_sequencer_monitor.sv
// checker: pin timing of the byte program sequencer
`timescale 1ns/1ps
module obp_sequencer_monitor
    import obp_pkg::*;
#(
    parameter int PULSE_CYC_P = PULSE_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // command and status
    input wire logic start,
    input wire logic busy,
    input wire logic done,
    input wire obp_pkg::obp_result_e result,
    // memory pins
    input wire logic [obp_pkg::ADDR_W-1:0] mem_addr,
    input wire obp_pkg::obp_strobe_s mem_strobe,
    input wire obp_pkg::obp_supply_s mem_supply,
    input wire logic [obp_pkg::DATA_W-1:0] mem_dq_out,
    input wire logic mem_dq_oe
);
    logic [31:0] low_cnt;
    logic [31:0] next_low_cnt;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    always_comb begin
        next_low_cnt = mem_strobe.program_strobe_n ? 32'h0 : low_cnt + 32'h1;
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt <= 32'h0;
        end else begin
            low_cnt <= next_low_cnt;
        end
    end
    chk_pulse_width:
    assert property ($rose(mem_strobe.program_strobe_n) |-> low_cnt == PULSE_CYC_P + 1)
        else $error("program pulse length wrong");
    chk_pulse_supply:
    assert property (!mem_strobe.program_strobe_n |-> mem_supply.vcc == SUP_PROG && mem_supply.vpp == SUP_PROG
        && !mem_strobe.ce_n && mem_dq_oe) else $error("pulse without program conditions");
    chk_pulse_stable:
    assert property (!mem_strobe.program_strobe_n && $past(!mem_strobe.program_strobe_n)
        |-> $stable(mem_addr) && $stable(mem_dq_out)) else $error("address or data moved in pulse");
    chk_supply_order:
    assert property (mem_supply.vpp <= mem_supply.vcc) else $error("program supply above core supply");
    chk_verify_read:
    assert property (!mem_strobe.oe_n |-> !mem_strobe.ce_n && !mem_dq_oe && mem_strobe.program_strobe_n)
        else $error("read with bad strobes");
    chk_done_pulse:
    assert property (done |-> !busy ##1 !done) else $error("done not a single pulse");
    chk_start_ramp:
    assert property (!busy && start |=> busy && mem_addr == '0 && mem_supply.vcc == SUP_PROG
        && mem_supply.vpp == $past(mem_supply.vpp)) else $error("run start wrong");
    chk_pass_supply:
    assert property (done && result == OBP_RES_PASS |-> mem_supply.vcc == SUP_NOM && mem_supply.vpp == SUP_NOM)
        else $error("pass without nominal supplies");
endmodule : obp_sequencer_monitor

bind obp_sequencer obp_sequencer_monitor #(.PULSE_CYC_P(PULSE_CYC_P)) u_obp_sequencer_monitor (
    .clk_sys(clk_sys), .rst_n(rst_n), .start(start), .busy(busy), .done(done), .result(result),
    .mem_addr(mem_addr), .mem_strobe(mem_strobe), .mem_supply(mem_supply), .mem_dq_out(mem_dq_out),
    .mem_dq_oe(mem_dq_oe));

// >>> dv/obp_sequencer_tb.sv
// testbench: program, retry, failure and identification runs
`timescale 1ns/1ps
module obp_sequencer_tb;
    import obp_pkg::*;
    logic clk_sys = 1'b0, rst_n = 1'b0, start = 1'b0, id_start = 1'b0, data_valid = 1'b0, wipe = 1'b0;
    logic [ADDR_W-1:0] last_addr = '0;
    logic [DATA_W-1:0] data_byte = '0;
    logic [3:0] hard_addr = 4'h0;
    logic [7:0] hard_n = 8'h1;
    logic data_ready, busy, done, mem_dq_oe;
    obp_result_e result;
    logic [ADDR_W-1:0] fail_addr, mem_addr;
    logic [DATA_W-1:0] maker_code, device_code, mem_dq_out, mem_dq_in, hard_pulses;
    obp_strobe_s mem_strobe;
    obp_supply_s mem_supply;
    logic [7:0] img [16];
    int n_fail = 0, samples_checked = 0;
    obp_sequencer #(.PULSE_CYC_P(20), .SETUP_CYC_P(4), .SUPPLY_CYC_P(4)) u_obp_sequencer (
        .clk_sys(clk_sys), .rst_n(rst_n), .start(start), .id_start(id_start), .last_addr(last_addr),
        .data_valid(data_valid), .data_ready(data_ready), .data_byte(data_byte), .busy(busy), .done(done),
        .result(result), .fail_addr(fail_addr), .maker_code(maker_code), .device_code(device_code),
        .mem_addr(mem_addr), .mem_strobe(mem_strobe), .mem_supply(mem_supply), .mem_dq_out(mem_dq_out),
        .mem_dq_oe(mem_dq_oe), .mem_dq_in(mem_dq_in));
    obp_otp_model #(.MAKER(8'h5a), .DEVICE(8'ha7)) u_obp_otp_model (
        .mem_addr(mem_addr), .mem_strobe(mem_strobe), .mem_supply(mem_supply), .mem_dq_out(mem_dq_out),
        .mem_dq_in(mem_dq_in), .wipe(wipe), .hard_addr(hard_addr), .hard_n(hard_n), .hard_pulses(hard_pulses));
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // fill optionally tops the fifo up until it refuses before the run starts
    task automatic run_prog(input int last, input bit fill);
        int k;
        logic tk, dn;
        k = 0;
        dn = 1'b0;
        wipe <= 1'b1;
        last_addr <= ADDR_W'(last);
        @(posedge clk_sys);
        // offer the first byte only once its acceptance can be counted
        wipe <= 1'b0;
        data_valid <= 1'b1;
        data_byte <= img[0];
        for (int t = 0; fill && t < 12; t++) begin
            @(negedge clk_sys);
            tk = data_ready;
            @(posedge clk_sys);
            if (tk) begin
                k++;
                data_byte <= img[k];
            end
        end
        if (fill) chk("fifo_fill", 18'h8, 18'(k));
        start <= 1'b1;
        for (int t = 0; t < 20000 && !dn; t++) begin
            @(negedge clk_sys);
            tk = data_valid && data_ready;
            dn = done;
            @(posedge clk_sys);
            start <= 1'b0;
            if (tk) begin
                k++;
                data_valid <= (k <= last);
                data_byte <= img[k % 16];
            end
        end
        data_valid <= 1'b0;
        chk("done_seen", 18'h1, 18'(dn));
    endtask : run_prog
    task automatic t_id;
        logic dn;
        dn = 1'b0;
        id_start <= 1'b1;
        for (int t = 0; t < 300 && !dn; t++) begin
            @(negedge clk_sys);
            dn = done;
            @(posedge clk_sys);
            id_start <= 1'b0;
        end
        chk("id_done", 18'h1, 18'(dn));
        chk("maker_code", 18'h5a, 18'(maker_code));
        chk("device_code", 18'ha7, 18'(device_code));
        $display("test id done");
    endtask : t_id
    task automatic t_clean;
        hard_addr <= 4'h3;
        hard_n <= 8'h1;
        run_prog(9, 1'b1);
        chk("result", 18'(OBP_RES_PASS), 18'(result));
        chk("pulses", 18'h1, 18'(hard_pulses));
        for (int i = 0; i < 11; i++) chk("cell", (i < 10) ? 18'(img[i]) : 18'hff, 18'(u_obp_otp_model.arr[i]));
        $display("test clean done");
    endtask : t_clean
    task automatic t_retry;
        hard_addr <= 4'h2;
        hard_n <= 8'h4;
        run_prog(3, 1'b0);
        chk("result", 18'(OBP_RES_PASS), 18'(result));
        chk("pulses", 18'h4, 18'(hard_pulses));
        chk("cell", 18'(img[2]), 18'(u_obp_otp_model.arr[2]));
        $display("test retry done");
    endtask : t_retry
    task automatic t_fail;
        hard_addr <= 4'h1;
        hard_n <= 8'hc;
        run_prog(3, 1'b0);
        chk("result", 18'(OBP_RES_FAIL), 18'(result));
        chk("fail_addr", 18'h1, 18'(fail_addr));
        chk("pulses", 18'hb, 18'(hard_pulses));
        $display("test fail done");
    endtask : t_fail
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (60000) @(posedge clk_sys);
        n_fail++;
        wrap_up();
    end
    initial begin
        foreach (img[i]) img[i] = 8'h35 ^ 8'(i * 17);
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_id();
        t_clean();
        t_retry();
        t_fail();
        t_id();
        wrap_up();
    end
endmodule : obp_sequencer_tb
